/* File: core/pssc_port_ctrl.sv */
// Purpose: Control-pin logic of a pipelined synchronous burst SRAM port
// Assumes: All pins come from outside the clock domain and are synchronised
// Notes: Synchronisers add two cycles of latency to every pin
`timescale 1ns/10ps
module pssc_port_ctrl
    import pssc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Address and strobes
    input wire logic [PSSC_ADDR_W-1:0] addr,
    input wire logic cpu_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    // Chip selects
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    // Write controls
    input wire logic all_bytes_write_n,
    input wire logic byte_write_en_n,
    input wire logic [PSSC_LANES-1:0] byte_lane_sel_n,
    // Asynchronous controls and strap
    input wire logic output_en_n,
    input wire logic sleep_req,
    input wire logic burst_order,
    // Data and parity lanes
    input wire logic [PSSC_DATA_W-1:0] data_in,
    input wire logic [PSSC_LANES-1:0] parity_lines_in,
    output logic [PSSC_DATA_W-1:0] data_out,
    output logic [PSSC_LANES-1:0] parity_lines_out,
    output logic data_oe,
    // Status
    output logic sleeping
);
    // Two-flop synchronisers for every pin; stage 0 feeds only stage 1
    localparam int SYNC_W = PSSC_ADDR_W + 8 + PSSC_LANES + PSSC_DATA_W + PSSC_LANES + 3;
    // Reset to idle pin levels so no phantom strobe or select follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {PSSC_ADDR_RST, 8'hff, PSSC_LANES_NONE, PSSC_DATA_RST, PSSC_PAR_RST,
                                               1'b1, 1'b0, 1'b1};
    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_q [PSSC_SYNC_STAGES];
    logic [SYNC_W-1:0] next_sync_q [PSSC_SYNC_STAGES];

    assign sync_raw = {addr, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, chip_sel_first_n,
                       chip_sel_second, chip_sel_third_n, all_bytes_write_n, byte_write_en_n,
                       byte_lane_sel_n, data_in, parity_lines_in, output_en_n, sleep_req, burst_order};

    always_comb begin
        next_sync_q[0] = sync_raw;
        next_sync_q[1] = sync_q[0];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync_q[0] <= SYNC_IDLE;
            sync_q[1] <= SYNC_IDLE;
        end else begin
            sync_q[0] <= next_sync_q[0];
            sync_q[1] <= next_sync_q[1];
        end
    end

    logic [PSSC_ADDR_W-1:0] s_addr;
    logic s_cpu_n, s_ctrl_n, s_step_n, s_cs1_n, s_cs2, s_cs3_n, s_gw_n, s_bwe_n;
    logic [PSSC_LANES-1:0] s_bw_n;
    logic [PSSC_DATA_W-1:0] s_data;
    logic [PSSC_LANES-1:0] s_par;
    logic s_oe_n, s_sleep, s_order;

    assign {s_addr, s_cpu_n, s_ctrl_n, s_step_n, s_cs1_n, s_cs2, s_cs3_n, s_gw_n, s_bwe_n,
            s_bw_n, s_data, s_par, s_oe_n, s_sleep, s_order} = sync_q[1];

    // Memory array: 8 data plus parity per lane
    logic [PSSC_BYTE_W:0] mem [PSSC_DEPTH][PSSC_LANES];

    function automatic logic [PSSC_LANES-1:0] lane_enables(input logic gw_n, input logic bwe_n,
                                                         input logic [PSSC_LANES-1:0] bw_n);
        if (!gw_n)
            return '1;
        else if (!bwe_n)
            return ~bw_n;
        else
            return '0;
    endfunction

    pssc_burst_if bif ();
    pssc_burst_counter u_burst (
        .core_clk(core_clk),
        .resetn(resetn),
        .bif(bif)
    );

    // Strobe decode
    logic selected, cpu_take, ctrl_take, any_strobe, desel_cmd;
    logic [PSSC_LANES-1:0] wr_lanes_now;
    assign selected = !s_cs1_n && s_cs2 && !s_cs3_n;
    assign cpu_take = !s_cpu_n && !s_cs1_n;
    assign ctrl_take = !s_ctrl_n && !cpu_take;
    assign any_strobe = cpu_take || ctrl_take;
    assign desel_cmd = any_strobe && !selected;
    assign wr_lanes_now = lane_enables(s_gw_n, s_bwe_n, s_bw_n);

    pssc_state_t state, next_state;
    logic [PSSC_ADDR_W-1:0] addr_reg, next_addr_reg;
    logic first_rd, next_first_rd;
    logic cpu_wr_pend, next_cpu_wr_pend;
    logic [PSSC_DATA_W-1:0] next_data_out;
    logic [PSSC_LANES-1:0] next_par_out;
    logic next_data_oe, next_sleeping;
    logic [PSSC_ADDR_W-1:0] cur_addr;
    logic [PSSC_LANES-1:0] do_wr;

    // Address used this cycle: burst offset replaces the low two bits
    assign cur_addr = {addr_reg[PSSC_ADDR_W-1:PSSC_BURST_W], bif.offset};

    always_comb begin
        next_state = state;
        next_addr_reg = addr_reg;
        next_first_rd = 1'b0;
        next_cpu_wr_pend = 1'b0;
        bif.load = 1'b0;
        bif.step = 1'b0;
        bif.start = s_addr[PSSC_BURST_W-1:0];
        bif.order = s_order ? PSSC_ORDER_INTERLEAVED : PSSC_ORDER_LINEAR;
        do_wr = '0;
        next_sleeping = s_sleep;
        if (s_sleep) begin
            // Pending accesses are abandoned; array content is kept
            next_state = PSSC_ST_IDLE;
        end else if (any_strobe) begin
            if (desel_cmd) begin
                next_state = PSSC_ST_IDLE;
            end else begin
                next_addr_reg = s_addr;
                bif.load = 1'b1;
                if (cpu_take) begin
                    // Write controls are not looked at in the strobe cycle
                    next_state = PSSC_ST_READ;
                    next_cpu_wr_pend = 1'b1;
                    next_first_rd = (state == PSSC_ST_IDLE);
                end else if (wr_lanes_now != '0) begin
                    next_state = PSSC_ST_WRITE;
                end else begin
                    next_state = PSSC_ST_READ;
                    next_first_rd = (state == PSSC_ST_IDLE);
                end
            end
        end else if (state != PSSC_ST_IDLE) begin
            bif.step = !s_step_n && !cpu_wr_pend;
            do_wr = wr_lanes_now;
            if (do_wr != '0)
                next_state = PSSC_ST_WRITE;
            else if (!cpu_wr_pend)
                next_state = PSSC_ST_READ;
            if (cpu_wr_pend && do_wr == '0)
                next_state = PSSC_ST_READ;
        end
        // Controller-strobe writes complete in the strobe cycle itself
        if (ctrl_take && selected && !s_sleep)
            do_wr = wr_lanes_now;
    end

    // Read data registered one stage after its address
    logic [PSSC_ADDR_W-1:0] rd_addr;
    always_comb begin
        rd_addr = (ctrl_take && selected) ? s_addr : cur_addr;
        if (cpu_take && selected)
            rd_addr = s_addr;
        // Output register only loads on reads, so it keeps the last read word through writes
        next_data_out = data_out;
        next_par_out = parity_lines_out;
        if (next_state == PSSC_ST_READ) begin
            for (int l = 0; l < PSSC_LANES; l++) begin
                next_data_out[l*PSSC_BYTE_W +: PSSC_BYTE_W] = mem[rd_addr][l][PSSC_BYTE_W-1:0];
                next_par_out[l] = mem[rd_addr][l][PSSC_BYTE_W];
            end
        end
        // Deselect keeps the previous drive for one more cycle, floats after
        next_data_oe = !s_oe_n && (next_state == PSSC_ST_READ) && !next_first_rd && !s_sleep;
        if (desel_cmd)
            next_data_oe = data_oe;
        if (do_wr != '0 || state == PSSC_ST_IDLE && !any_strobe)
            next_data_oe = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        for (int l = 0; l < PSSC_LANES; l++) begin
            if (do_wr[l])
                mem[(ctrl_take && selected) ? s_addr : cur_addr][l] <=
                    {s_par[l], s_data[l*PSSC_BYTE_W +: PSSC_BYTE_W]};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= PSSC_ST_IDLE;
            addr_reg <= PSSC_ADDR_RST;
            first_rd <= 1'b0;
            cpu_wr_pend <= 1'b0;
            data_out <= PSSC_DATA_RST;
            parity_lines_out <= PSSC_PAR_RST;
            data_oe <= 1'b0;
            sleeping <= 1'b0;
        end else begin
            state <= next_state;
            addr_reg <= next_addr_reg;
            first_rd <= next_first_rd;
            cpu_wr_pend <= next_cpu_wr_pend;
            data_out <= next_data_out;
            parity_lines_out <= next_par_out;
            data_oe <= next_data_oe;
            sleeping <= next_sleeping;
        end
    end
endmodule

/* File: inc/pssc_pkg.sv */
// Purpose: Shared constants and types for the pipelined sync SRAM port control
// Assumes: 32K x 36 organisation, four byte lanes of 8 data plus 1 parity
// Notes: No registers reachable by software
package pssc_pkg;
    localparam int PSSC_ADDR_W = 15;
    localparam int PSSC_LANES = 4;
    localparam int PSSC_BYTE_W = 8;
    localparam int PSSC_DATA_W = PSSC_LANES * PSSC_BYTE_W;
    localparam int PSSC_DEPTH = 32768;
    localparam int PSSC_BURST_W = 2;
    localparam logic [PSSC_BURST_W-1:0] PSSC_BURST_ONE = 2'h1;
    localparam logic [PSSC_BURST_W-1:0] PSSC_BURST_ZERO = 2'h0;
    localparam logic [PSSC_ADDR_W-1:0] PSSC_ADDR_RST = 15'h0000;
    localparam logic [PSSC_DATA_W-1:0] PSSC_DATA_RST = 32'h0000_0000;
    localparam logic [PSSC_LANES-1:0] PSSC_PAR_RST = 4'h0;
    localparam logic [PSSC_LANES-1:0] PSSC_LANES_NONE = 4'hf;
    localparam int PSSC_SYNC_STAGES = 2;

    typedef enum logic {
        PSSC_ORDER_LINEAR,
        PSSC_ORDER_INTERLEAVED
    } pssc_order_t;

    typedef enum logic [1:0] {
        PSSC_ST_IDLE,
        PSSC_ST_READ,
        PSSC_ST_WRITE
    } pssc_state_t;
endpackage

/* File: inc/pssc_burst_if.sv */
// Purpose: Carries burst counter controls between the port control and its counter
// Assumes: Single clock domain
// Notes: Control side loads or steps, counter side reports the current offset
`timescale 1ns/10ps
interface pssc_burst_if;
    import pssc_pkg::*;
    logic load;
    logic step;
    logic [PSSC_BURST_W-1:0] start;
    pssc_order_t order;
    logic [PSSC_BURST_W-1:0] offset;
    logic valid;
    modport ctrl (output load, output step, output start, output order, input offset, input valid);
    modport cnt (input load, input step, input start, input order, output offset, output valid);
endinterface

/* File: core/pssc_burst_counter.sv */
// Purpose: Two-bit wraparound burst counter, linear or interleaved
// Assumes: Load has priority over step
// Notes: Holds no valid address until the first load
`timescale 1ns/10ps
module pssc_burst_counter
    import pssc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control
    pssc_burst_if.cnt bif
);
    logic [PSSC_BURST_W-1:0] first;
    logic [PSSC_BURST_W-1:0] count;
    logic vld;
    logic [PSSC_BURST_W-1:0] next_first;
    logic [PSSC_BURST_W-1:0] next_count;
    logic next_vld;

    always_comb begin
        next_first = first;
        next_count = count;
        next_vld = vld;
        if (bif.load) begin
            next_first = bif.start;
            next_count = PSSC_BURST_ZERO;
            next_vld = 1'b1;
        end else if (bif.step && vld) begin
            // Two-bit add wraps modulo four by width
            next_count = count + PSSC_BURST_ONE;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            first <= PSSC_BURST_ZERO;
            count <= PSSC_BURST_ZERO;
            vld <= 1'b0;
        end else begin
            first <= next_first;
            count <= next_count;
            vld <= next_vld;
        end
    end

    // Interleaved xors the step count in, linear adds it
    assign bif.offset = (bif.order == PSSC_ORDER_INTERLEAVED) ? (first ^ count) : (first + count);
    assign bif.valid = vld;
endmodule

/* File: test/pssc_port_ctrl_assertions.sv */
// Purpose: Port-level checks for the SRAM port control
// Assumes: Pins pass a two-flop synchroniser before use
// Notes: Windows are sized for that synchroniser latency
`timescale 1ns/10ps
module pssc_port_ctrl_assertions
    import pssc_pkg::*;
(
    // Clock, reset and pins
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cpu_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic output_en_n,
    input wire logic sleep_req,
    // Outputs
    input wire logic [PSSC_DATA_W-1:0] data_out,
    input wire logic [PSSC_LANES-1:0] parity_lines_out,
    input wire logic data_oe,
    input wire logic sleeping
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    logic sel;
    logic start;
    logic desel;
    logic idle;
    logic next_idle;
    assign sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
    assign start = sel && (!cpu_addr_strobe_n || !ctrl_addr_strobe_n);
    assign desel = !sel && !ctrl_addr_strobe_n;
    // Mask is only judged from idle, since a read after a write is not masked
    always_comb next_idle = desel ? 1'b1 : (start ? 1'b0 : idle);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) idle <= 1'b1;
        else idle <= next_idle;
    end
    a_oe_high_floats: assert property (output_en_n [*4] |-> !data_oe)
        else $error("driving while output enable off");
    a_first_read_masked: assert property (start && idle |-> ##3 !data_oe)
        else $error("driving in first cycle after deselect");
    a_cpu_ignored: assert property (idle && !data_oe && chip_sel_first_n && ctrl_addr_strobe_n
        && !cpu_addr_strobe_n |-> ##1 !data_oe [*3]) else $error("processor strobe taken");
    a_desel_hold: assert property (desel && data_oe && !output_en_n |=> data_oe ##[1:5] !data_oe)
        else $error("deselect hold wrong");
    a_reset_floats: assert property ($rose(resetn) |-> !data_oe [*3])
        else $error("driving after reset");
    a_reset_clears: assert property ($rose(resetn) |-> !sleeping && data_out == PSSC_DATA_RST
        && parity_lines_out == PSSC_PAR_RST) else $error("outputs not cleared");
    a_sleep_enter: assert property ($rose(sleep_req) |-> ##[1:4] sleeping)
        else $error("sleep not entered");
    a_sleep_exit: assert property (!sleep_req [*4] |-> !sleeping)
        else $error("sleeping without request");
    c_fresh_read: cover property (start && idle);
    c_desel_on: cover property (desel && data_oe);
    c_sleep: cover property ($rose(sleeping));
endmodule
bind pssc_port_ctrl pssc_port_ctrl_assertions u_chk (.core_clk, .resetn, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
    .chip_sel_first_n, .chip_sel_second, .chip_sel_third_n, .output_en_n, .sleep_req, .data_out,
    .parity_lines_out, .data_oe, .sleeping);

/* File: test/pssc_host_model.sv */
// Purpose: Host side of the shared data and parity wires
// Assumes: Host drives only while the port is floating
// Notes: Released wires toggle so stale values are never seen
`timescale 1ns/10ps
module pssc_host_model
    import pssc_pkg::*;
(
    // Host side
    input wire logic core_clk,
    input wire logic host_en,
    input wire logic [PSSC_DATA_W-1:0] host_data,
    input wire logic [PSSC_LANES-1:0] host_par,
    // Port side
    input wire logic [PSSC_DATA_W-1:0] data_out,
    input wire logic [PSSC_LANES-1:0] parity_lines_out,
    input wire logic data_oe,
    output logic [PSSC_DATA_W-1:0] data_in,
    output logic [PSSC_LANES-1:0] parity_lines_in
);
    logic [35:0] last = '0;
    always_comb begin
        if (data_oe) {parity_lines_in, data_in} = {parity_lines_out, data_out};
        else if (host_en) {parity_lines_in, data_in} = {host_par, host_data};
        else {parity_lines_in, data_in} = ~last;
    end
    always @(posedge core_clk) last <= {parity_lines_in, data_in};
endmodule

/* File: test/tb_pipelined_sync_sram_port_control.sv */
// Purpose: Self-checking bench for the SRAM port control
// Assumes: Pins act two edges late, read data one edge after that
// Notes: Expected memory contents come from the row table
`timescale 1ns/10ps
module tb_pipelined_sync_sram_port_control;
    import pssc_pkg::*;
    typedef struct packed {
        logic [PSSC_ADDR_W-1:0] a;
        logic [PSSC_DATA_W-1:0] d;
        logic [PSSC_LANES-1:0] p;
        logic gw_n;
        logic [PSSC_LANES-1:0] bw_n;
        logic [35:0] e;
    } pssc_row_t;
    logic core_clk = 1'b0, resetn = 1'b0, host_en = 1'b0, data_oe, sleeping;
    logic cpu_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1, burst_step_n = 1'b1;
    logic chip_sel_first_n = 1'b0, chip_sel_second = 1'b1, chip_sel_third_n = 1'b0;
    logic all_bytes_write_n = 1'b1, byte_write_en_n = 1'b1, output_en_n = 1'b0;
    logic sleep_req = 1'b0, burst_order = 1'b1;
    logic [PSSC_ADDR_W-1:0] addr = PSSC_ADDR_RST;
    logic [PSSC_LANES-1:0] byte_lane_sel_n = PSSC_LANES_NONE, host_par = PSSC_PAR_RST, parity_lines_in, parity_lines_out;
    logic [PSSC_DATA_W-1:0] host_data = PSSC_DATA_RST, data_in, data_out;
    logic [35:0] mem [int];
    int n_fail = 0, n_checks = 0;
    pssc_row_t rows [7] = '{
        '{15'h0010, 32'h1234_5678, 4'h5, 1'b0, 4'hf, 36'h5_1234_5678},
        '{15'h0011, 32'h9abc_def0, 4'ha, 1'b0, 4'hf, 36'ha_9abc_def0},
        '{15'h0012, 32'h0f0f_0f0f, 4'h3, 1'b0, 4'hf, 36'h3_0f0f_0f0f},
        '{15'h0013, 32'hfedc_ba98, 4'hc, 1'b0, 4'hf, 36'hc_fedc_ba98},
        '{15'h0010, 32'haaaa_5555, 4'hf, 1'b1, 4'ha, 36'h5_12aa_5655},
        '{15'h0011, 32'h0000_0000, 4'h0, 1'b1, 4'hf, 36'ha_9abc_def0},
        '{15'h7fff, 32'hffff_ffff, 4'hf, 1'b0, 4'hf, 36'hf_ffff_ffff}};
    always #5 core_clk = ~core_clk;
    pssc_port_ctrl dut (.core_clk, .resetn, .addr, .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n,
        .chip_sel_first_n, .chip_sel_second, .chip_sel_third_n, .all_bytes_write_n, .byte_write_en_n,
        .byte_lane_sel_n, .output_en_n, .sleep_req, .burst_order, .data_in, .parity_lines_in, .data_out,
        .parity_lines_out, .data_oe, .sleeping);
    pssc_host_model u_host (.core_clk, .host_en, .host_data, .host_par, .data_out, .parity_lines_out,
        .data_oe, .data_in, .parity_lines_in);
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] k);
        return burst_order ? s ^ k : s + k;
    endfunction
    task automatic rest(input logic step_n);
        {cpu_addr_strobe_n, ctrl_addr_strobe_n, all_bytes_write_n, byte_write_en_n} <= 4'hf;
        {chip_sel_first_n, chip_sel_third_n, host_en} <= 3'h0;
        burst_step_n <= step_n;
    endtask
    task automatic drive(input logic cp_n, input logic cc_n, input pssc_row_t r, input logic bwe_n);
        @(posedge core_clk);
        {cpu_addr_strobe_n, ctrl_addr_strobe_n, all_bytes_write_n, byte_write_en_n} <= {cp_n, cc_n, r.gw_n, bwe_n};
        {addr, byte_lane_sel_n, host_data, host_par} <= {r.a, r.bw_n, r.d, r.p};
        host_en <= !bwe_n || !r.gw_n;
    endtask
    task automatic rd(input logic cpu, input logic [PSSC_ADDR_W-1:0] a, input int steps, input logic fresh);
        pssc_row_t r;
        int k;
        r = '0;
        r.a = a;
        r.gw_n = 1'b1;
        drive(!cpu, cpu, r, 1'b1);
        for (int i = 0; i <= steps + 4; i++) begin
            @(posedge core_clk);
            rest(i >= steps);
            if (i >= 2) begin
                // Step seen three edges later; processor strobe ignores the first step
                k = (steps + 1 < i - 2 ? steps + 1 : i - 2) - (cpu ? 3 : 2) + 1;
                if (k < 0) k = 0;
                #1;
                chk({parity_lines_out, data_out}, mem[{a[PSSC_ADDR_W-1:2], nxt(a[1:0], 2'(k))}]);
                if (fresh || i > 2) chk(data_oe, (i > 2) && !output_en_n);
            end
        end
    endtask
    task automatic wr(input pssc_row_t r);
        // Host turns the port's drivers off before it puts data on the shared wires
        @(posedge core_clk);
        output_en_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        drive(1'b1, 1'b0, r, !r.gw_n);
        @(posedge core_clk);
        rest(1'b1);
        output_en_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        mem[r.a] = r.e;
    endtask
    task automatic desel(input logic was_on);
        @(posedge core_clk);
        ctrl_addr_strobe_n <= 1'b0;
        chip_sel_third_n <= 1'b1;
        @(posedge core_clk);
        rest(1'b1);
        repeat (2) @(posedge core_clk);
        #1;
        if (was_on) chk(data_oe, 1'b1);
        @(posedge core_clk);
        #1;
        chk(data_oe, 1'b0);
        repeat (3) @(posedge core_clk);
    endtask
    task automatic reset_dut;
        resetn <= 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        #1;
        chk({data_oe, sleeping, parity_lines_out, data_out}, 40'h00_0000_0000);
    endtask
    initial begin
        reset_dut();
        foreach (rows[i]) begin
            wr(rows[i]);
            rd(1'b0, rows[i].a, 0, 1'b0);
        end
        for (int o = 0; o < 2; o++) begin
            burst_order <= o[0];
            desel(1'b1);
            rd(1'b1, 15'h0011, 3, 1'b1);
        end
        desel(1'b1);
        drive(1'b0, 1'b0, rows[0], 1'b1);
        @(posedge core_clk);
        rest(1'b1);
        repeat (3) @(posedge core_clk);
        #1;
        chk({parity_lines_out, data_out}, mem[15'h0010]);
        desel(1'b1);
        @(posedge core_clk);
        chip_sel_first_n <= 1'b1;
        cpu_addr_strobe_n <= 1'b0;
        @(posedge core_clk);
        rest(1'b1);
        repeat (5) @(posedge core_clk);
        #1;
        chk(data_oe, 1'b0);
        output_en_n <= 1'b1;
        rd(1'b0, 15'h0013, 0, 1'b1);
        repeat (3) @(posedge core_clk);
        #1;
        chk(data_oe, 1'b0);
        desel(1'b0);
        output_en_n <= 1'b0;
        sleep_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk(sleeping, 1'b1);
        sleep_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        chk(sleeping, 1'b0);
        repeat (4) @(posedge core_clk);
        rd(1'b0, 15'h0012, 0, 1'b1);
        reset_dut();
        print_verdict();
    end
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end
endmodule
